// file: verilog/tetc_pkg.sv
// Package for the touch event trigger configuration bank.
// Assumes byte-wide register port; 16-bit delays split in byte registers.
package tetc_pkg;

  // Register offsets (byte registers)
  localparam logic [3:0] ADDR_TRIG      = 4'h0;
  localparam logic [3:0] ADDR_QSETUP    = 4'h1;
  localparam logic [3:0] ADDR_PERIOD    = 4'h2;
  localparam logic [3:0] ADDR_XDLY_HI   = 4'h3;
  localparam logic [3:0] ADDR_XDLY_LO   = 4'h4;
  localparam logic [3:0] ADDR_YDLY_HI   = 4'h5;
  localparam logic [3:0] ADDR_YDLY_LO   = 4'h6;
  localparam logic [3:0] ADDR_ZDLY_HI   = 4'h7;
  localparam logic [3:0] ADDR_ZDLY_LO   = 4'h8;
  localparam logic [3:0] ADDR_STATUS    = 4'h9;

  // Trigger register bit positions
  localparam int BIT_REL   = 7;
  localparam int BIT_CAL   = 6;
  localparam int BIT_PINCH = 5;
  localparam int BIT_ROT   = 4;
  localparam int BIT_SLD   = 3;
  localparam int BIT_QLVL  = 2;
  localparam int BIT_CAP   = 1;
  localparam int BIT_RES   = 0;

  // Queue setup fields
  localparam int BIT_QEN   = 4;
  localparam int QTH_MSB   = 3;

  // Reset values
  localparam logic [7:0]  TRIG_RST   = 8'h00;
  localparam logic [7:0]  QSETUP_RST = 8'h00;
  localparam logic [7:0]  PERIOD_RST = 8'h0a;
  localparam logic [15:0] DLY_RST    = 16'h0064;

  // Sample queue geometry and period limits
  localparam int          QUEUE_DEPTH = 16;
  localparam logic [4:0]  QUEUE_FULL  = 5'h10;
  localparam logic [7:0]  PERIOD_MIN  = 8'h05;
  localparam logic [7:0]  PERIOD_MAX  = 8'h64;

  // Timing
  localparam int CLK_HZ        = 40000000;
  localparam int US_PER_S      = 1000000;
  localparam int CYC_PER_US    = CLK_HZ / US_PER_S;
  localparam int CYC_PER_MS    = CYC_PER_US * 1000;

  typedef enum logic [2:0] {
    TETC_IDLE   = 3'b000,
    TETC_XWAIT  = 3'b001,
    TETC_YWAIT  = 3'b010,
    TETC_ZWAIT  = 3'b011,
    TETC_DONE   = 3'b100
  } tetc_scan_t;

  // Touch-side events, one-cycle pulses from the scanning logic
  typedef struct packed {
    logic release_ev;
    logic pinch_ev;
    logic rotate_ev;
    logic slide_ev;
    logic cap_ev;
    logic res_ev;
  } tetc_events_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tetc_bus_t;

endpackage : tetc_pkg

// file: verilog/tetc_top.sv
// Trigger, sample-queue, scan-period and settle-delay configuration bank.
// Assumes a simple strobe bus and event pulses synchronous to sys_clk.
// Overview of operation
// - A set trigger bit lets its event drive the pending pin; clear blocks it.
// - Trigger bits keep value across power loss except calibration bit 6.
// - Setting bit 6 enters calibration; writing zero during it aborts.
// - Calibration ends when all points found or on reset.
// - Bit 7 raises pending when the screen is released.
// - Bit 5 raises pending on zoom-in or zoom-out gesture.
// - Rotate trigger at bit 4 raises pending on either rotation.
// - Slide trigger at bit 3 raises pending on any slide.
// - Bit 2 raises pending when queue count reaches the watermark.
// - Bit 1 raises pending on any enabled capacitive event.
// - Bit 0 raises pending on each resistive event.
// - Any write to queue setup flushes all stored samples.
// - Queue enable at bit 4 stores each resistive result until the queue holds 16.
// - Watermark bits 3-0; count at or above it sets level flag.
// - Watermark zero means full only; 1 to 15 fires at that count.
// - Scan period in ms, host writes 5 to 100 (any byte written is stored, no clamp to 5-100), one scan per period.
// - X settle delay of 16 bits in microseconds before X sample.
// - Y settle delay of 16 bits in microseconds before Y sample.
// - Pressure settle delay of 16 bits before pressure sample.
// - Delay upper byte in bits 15-8, lower byte in bits 7-0.
// - Calibration loads delays; host writes also accepted.
`timescale 1ns/10ps
`default_nettype none
module tetc_top
  import tetc_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // Register port
  input  wire tetc_pkg::tetc_bus_t bus,
  output logic [7:0]               rdata,
  // Retained trigger image, restored after power loss
  input  wire logic [7:0]          nv_trig,
  input  wire logic                nv_load,
  // Touch and calibration side
  input  wire tetc_pkg::tetc_events_t events,
  input  wire logic                cal_points_done,
  input  wire logic                cal_dly_valid,
  input  wire logic [15:0]         cal_x_dly,
  input  wire logic [15:0]         cal_y_dly,
  input  wire logic [15:0]         cal_z_dly,
  input  wire logic                sample_valid,
  input  wire logic                sample_pop,
  // Outputs
  output logic                     calibrating,
  output logic                     scan_tick,
  output logic [2:0]               sample_strobe,
  output logic [4:0]               queue_count,
  output logic                     queue_level_flag,
  output logic                     activity_pending_pin
);
  import tetc_pkg::*;

  logic [7:0]  trig_q, trig_d;
  logic [7:0]  qset_q, qset_d;
  logic [7:0]  per_q, per_d;
  logic [15:0] xd_q, xd_d, yd_q, yd_d, zd_q, zd_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [5:0]  pend_q, pend_d;
  logic        lvl_pend_q, lvl_pend_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [21:0] ptim_q, ptim_d;
  logic [21:0] dtim_q, dtim_d;
  tetc_scan_t  st_q, st_d;
  logic [2:0]  strb_q, strb_d;
  logic        tick_q, tick_d;
  logic        level_hit, cal_wr, push;
  logic [5:0]  ev_vec, en_vec;
  logic [21:0] per_cyc;

  // Event bits ordered release, pinch, rotate, slide, cap, resistive
  assign ev_vec = {events.release_ev, events.pinch_ev, events.rotate_ev,
                   events.slide_ev, events.cap_ev, events.res_ev};
  assign en_vec = {trig_q[BIT_REL],
                   trig_q[BIT_PINCH],
                   trig_q[BIT_ROT],
                   trig_q[BIT_SLD],
                   trig_q[BIT_CAP],
                   trig_q[BIT_RES]};

  assign cal_wr = bus.wr && (bus.addr == ADDR_TRIG);
  assign push   = sample_valid && qset_q[BIT_QEN] && (cnt_q != QUEUE_FULL);

  // Zero watermark means fire on full only
  always_comb begin
    if (qset_q[QTH_MSB:0] == 4'h0) begin
      level_hit = (cnt_q == QUEUE_FULL);
    end else begin
      level_hit = (cnt_q >= {1'b0, qset_q[QTH_MSB:0]});
    end
  end

  assign per_cyc = 22'(per_q) * 22'(CYC_PER_MS);

  // Register bank, queue count and read data
  always_comb begin
    trig_d  = trig_q;
    qset_d  = qset_q;
    per_d   = per_q;
    xd_d    = xd_q;
    yd_d    = yd_q;
    zd_d    = zd_q;
    cnt_d   = cnt_q;
    rdata_d = 8'h00;
    if (nv_load) begin
      trig_d = {nv_trig[7], 1'b0, nv_trig[5:0]};
    end
    if (trig_q[BIT_CAL] && cal_points_done) begin
      trig_d[BIT_CAL] = 1'b0;
    end
    if (push) begin
      cnt_d = cnt_q + 5'h01;
    end else if (sample_pop && cnt_q != 5'h00) begin
      cnt_d = cnt_q - 5'h01;
    end
    if (trig_q[BIT_CAL] && cal_dly_valid) begin
      xd_d = cal_x_dly;
      yd_d = cal_y_dly;
      zd_d = cal_z_dly;
    end
    if (bus.wr) begin
      case (bus.addr)
        ADDR_TRIG:    trig_d = bus.wdata;
        ADDR_QSETUP: begin
          qset_d = {3'h0, bus.wdata[4:0]};
          cnt_d  = 5'h00;
        end
        ADDR_PERIOD:  per_d = bus.wdata;
        ADDR_XDLY_HI: xd_d[15:8] = bus.wdata;
        ADDR_XDLY_LO: xd_d[7:0]  = bus.wdata;
        ADDR_YDLY_HI: yd_d[15:8] = bus.wdata;
        ADDR_YDLY_LO: yd_d[7:0]  = bus.wdata;
        ADDR_ZDLY_HI: zd_d[15:8] = bus.wdata;
        ADDR_ZDLY_LO: zd_d[7:0]  = bus.wdata;
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_TRIG:    rdata_d = trig_q;
        ADDR_QSETUP:  rdata_d = qset_q;
        ADDR_PERIOD:  rdata_d = per_q;
        ADDR_XDLY_HI: rdata_d = xd_q[15:8];
        ADDR_XDLY_LO: rdata_d = xd_q[7:0];
        ADDR_YDLY_HI: rdata_d = yd_q[15:8];
        ADDR_YDLY_LO: rdata_d = yd_q[7:0];
        ADDR_ZDLY_HI: rdata_d = zd_q[15:8];
        ADDR_ZDLY_LO: rdata_d = zd_q[7:0];
        ADDR_STATUS:  rdata_d = {1'b0, lvl_pend_q, pend_q};
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  // Sticky pending bits; a new event wins over the status read clear
  always_comb begin
    pend_d     = pend_q;
    lvl_pend_d = lvl_pend_q;
    if (bus.rd && bus.addr == ADDR_STATUS) begin
      pend_d     = 6'h00;
      lvl_pend_d = 1'b0;
    end
    pend_d = pend_d | (ev_vec & en_vec);
    if (level_hit && trig_q[BIT_QLVL]) begin
      lvl_pend_d = 1'b1;
    end
  end

  // Scan period timer and settle sequence
  always_comb begin
    ptim_d = ptim_q + 22'h1;
    tick_d = 1'b0;
    st_d   = st_q;
    dtim_d = dtim_q;
    strb_d = 3'b000;
    if (ptim_q + 22'h1 >= per_cyc) begin
      ptim_d = 22'h0;
      tick_d = 1'b1;
    end
    case (st_q)
      TETC_IDLE: begin
        if (tick_q) begin
          st_d   = TETC_XWAIT;
          dtim_d = 22'(xd_q) * 22'(CYC_PER_US);
        end
      end
      TETC_XWAIT: begin
        if (dtim_q == 22'h0) begin
          strb_d = 3'b001;
          st_d   = TETC_YWAIT;
          dtim_d = 22'(yd_q) * 22'(CYC_PER_US);
        end else begin
          dtim_d = dtim_q - 22'h1;
        end
      end
      TETC_YWAIT: begin
        if (dtim_q == 22'h0) begin
          strb_d = 3'b010;
          st_d   = TETC_ZWAIT;
          dtim_d = 22'(zd_q) * 22'(CYC_PER_US);
        end else begin
          dtim_d = dtim_q - 22'h1;
        end
      end
      TETC_ZWAIT: begin
        if (dtim_q == 22'h0) begin
          strb_d = 3'b100;
          st_d   = TETC_DONE;
        end else begin
          dtim_d = dtim_q - 22'h1;
        end
      end
      TETC_DONE: st_d = TETC_IDLE;
      default:   st_d = TETC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_q     <= TRIG_RST;
      qset_q     <= QSETUP_RST;
      per_q      <= PERIOD_RST;
      xd_q       <= DLY_RST;
      yd_q       <= DLY_RST;
      zd_q       <= DLY_RST;
      cnt_q      <= 5'h00;
      pend_q     <= 6'h00;
      lvl_pend_q <= 1'b0;
      rdata_q    <= 8'h00;
      ptim_q     <= 22'h0;
      dtim_q     <= 22'h0;
      st_q       <= TETC_IDLE;
      strb_q     <= 3'b000;
      tick_q     <= 1'b0;
    end else begin
      trig_q     <= trig_d;
      qset_q     <= qset_d;
      per_q      <= per_d;
      xd_q       <= xd_d;
      yd_q       <= yd_d;
      zd_q       <= zd_d;
      cnt_q      <= cnt_d;
      pend_q     <= pend_d;
      lvl_pend_q <= lvl_pend_d;
      rdata_q    <= rdata_d;
      ptim_q     <= ptim_d;
      dtim_q     <= dtim_d;
      st_q       <= st_d;
      strb_q     <= strb_d;
      tick_q     <= tick_d;
    end
  end

  assign rdata                = rdata_q;
  assign calibrating          = trig_q[BIT_CAL];
  assign scan_tick            = tick_q;
  assign sample_strobe        = strb_q;
  assign queue_count          = cnt_q;
  assign queue_level_flag     = level_hit;
  assign activity_pending_pin = (|pend_q) | lvl_pend_q;

  // Checks
  property p_cal_abort;
    @(posedge sys_clk) disable iff (!rst_b)
      cal_wr && !bus.wdata[BIT_CAL] |=> !calibrating;
  endproperty
  a_cal_abort: assert property (p_cal_abort)
    else $error("calibration not aborted");

  property p_cal_done;
    @(posedge sys_clk) disable iff (!rst_b)
      calibrating && cal_points_done && !cal_wr |=> !calibrating;
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("calibration did not end");

  property p_flush;
    @(posedge sys_clk) disable iff (!rst_b)
      bus.wr && bus.addr == ADDR_QSETUP |=> queue_count == 5'h00;
  endproperty
  a_flush: assert property (p_flush)
    else $error("queue not flushed");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_b)
      events.release_ev && trig_q[BIT_REL] |=> activity_pending_pin;
  endproperty
  a_release: assert property (p_release)
    else $error("release did not raise pending");

  property p_masked;
    @(posedge sys_clk) disable iff (!rst_b)
      !activity_pending_pin && trig_q == 8'h00 && !nv_load
      |=> !activity_pending_pin;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked event raised pending");

  property p_level;
    @(posedge sys_clk) disable iff (!rst_b)
      qset_q[QTH_MSB:0] != 4'h0 && cnt_q >= {1'b0, qset_q[QTH_MSB:0]}
      |-> queue_level_flag;
  endproperty
  a_level: assert property (p_level)
    else $error("level flag missing");

  property p_zero_wm;
    @(posedge sys_clk) disable iff (!rst_b)
      qset_q[QTH_MSB:0] == 4'h0 && cnt_q != QUEUE_FULL |-> !queue_level_flag;
  endproperty
  a_zero_wm: assert property (p_zero_wm)
    else $error("zero watermark fired early");

  property p_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      bus.rd && bus.addr == ADDR_STATUS && ev_vec == 6'h00 && !level_hit
      |=> !activity_pending_pin;
  endproperty
  a_clear: assert property (p_clear)
    else $error("pending not cleared by read");

  property p_nv;
    @(posedge sys_clk) disable iff (!rst_b)
      nv_load && !bus.wr |=> !trig_q[BIT_CAL];
  endproperty
  a_nv: assert property (p_nv)
    else $error("calibration bit restored");

  property p_level_pend;
    @(posedge sys_clk) disable iff (!rst_b)
      queue_level_flag && trig_q[BIT_QLVL] |=> activity_pending_pin;
  endproperty
  a_level_pend: assert property (p_level_pend)
    else $error("queue level did not raise pending");

  property p_pinch;
    @(posedge sys_clk) disable iff (!rst_b)
      events.pinch_ev && trig_q[BIT_PINCH] |=> activity_pending_pin;
  endproperty
  a_pinch: assert property (p_pinch)
    else $error("pinch did not raise pending");

  property p_rotate;
    @(posedge sys_clk) disable iff (!rst_b)
      events.rotate_ev && trig_q[BIT_ROT] |=> activity_pending_pin;
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate did not raise pending");

  property p_slide;
    @(posedge sys_clk) disable iff (!rst_b)
      events.slide_ev && trig_q[BIT_SLD] |=> activity_pending_pin;
  endproperty
  a_slide: assert property (p_slide)
    else $error("slide did not raise pending");

  property p_cap;
    @(posedge sys_clk) disable iff (!rst_b)
      events.cap_ev && trig_q[BIT_CAP] |=> activity_pending_pin;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capacitive event did not raise pending");

  property p_push;
    @(posedge sys_clk) disable iff (!rst_b)
      push && !(bus.wr && bus.addr == ADDR_QSETUP)
      |=> queue_count == $past(cnt_q) + 5'h01;
  endproperty
  a_push: assert property (p_push)
    else $error("stored sample not counted");

  c_cal:   cover property (@(posedge sys_clk) calibrating ##1 !calibrating);
  c_flush: cover property (@(posedge sys_clk) cnt_q != 5'h00 ##1 cnt_q == 5'h00);
  c_pend:  cover property (@(posedge sys_clk) activity_pending_pin);
  c_scan:  cover property (@(posedge sys_clk) sample_strobe == 3'b100);

endmodule : tetc_top
`default_nettype wire

// file: sim/tetc_host_model.sv
// Host-side register master for the trigger configuration bank.
// Assumes byte registers and read data valid only the cycle after a read.
`timescale 1ns/10ps
`default_nettype none
module tetc_host_model (
  // Clock
  input  wire logic                sys_clk,
  // Register port
  output var tetc_pkg::tetc_bus_t  bus,
  input  wire logic [7:0]          rdata
);
  import tetc_pkg::*;

  initial bus = '0;

  // One-cycle write strobe; also carries calibration and delay writes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
    // Callers look at outputs only after the write has landed
    #1;
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd
endmodule : tetc_host_model
`default_nettype wire

// file: sim/touch_event_trigger_config_tb.sv
// Self-checking bench for the trigger configuration bank.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
`default_nettype none
module touch_event_trigger_config_tb;
  import tetc_pkg::*;

  logic         sys_clk, rst_b, nv_load, cal_points_done, cal_dly_valid;
  logic         sample_valid, sample_pop, calibrating, scan_tick;
  logic         queue_level_flag, activity_pending_pin;
  logic [7:0]   rdata, nv_trig;
  logic [15:0]  cal_dly;
  logic [2:0]   sample_strobe;
  logic [4:0]   queue_count;
  tetc_bus_t    bus;
  tetc_events_t ev;
  int           bad_count, n_compared, cyc;

  tetc_host_model tetc_host_model_i (.sys_clk(sys_clk), .bus(bus),
    .rdata(rdata));
  tetc_top tetc_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .nv_trig(nv_trig), .nv_load(nv_load), .events(ev),
    .cal_points_done(cal_points_done), .cal_dly_valid(cal_dly_valid),
    .cal_x_dly(cal_dly), .cal_y_dly(cal_dly ^ 16'h0101),
    .cal_z_dly(~cal_dly), .sample_valid(sample_valid),
    .sample_pop(sample_pop), .calibrating(calibrating),
    .scan_tick(scan_tick), .sample_strobe(sample_strobe),
    .queue_count(queue_count), .queue_level_flag(queue_level_flag),
    .activity_pending_pin(activity_pending_pin));

  always #12.5 sys_clk = ~sys_clk;

  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 100000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    tetc_host_model_i.wr(a, d);
  endtask : w

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    tetc_host_model_i.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rdc

  // Pulse a touch event for one cycle
  task automatic fire(input logic [5:0] v);
    @(posedge sys_clk);
    ev <= tetc_events_t'(v);
    @(posedge sys_clk);
    ev <= '0;
    #1;
  endtask : fire

  task automatic push(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      @(posedge sys_clk);
      sample_valid <= 1'b0;
    end
    #1;
  endtask : push

  task automatic t_scan;
    int tx, ty, tz, tp, c;
    w(ADDR_PERIOD, 8'h01);
    for (logic [3:0] a = ADDR_XDLY_HI; a <= ADDR_ZDLY_LO; a++) begin
      w(a, a[0] ? 8'h00 : {5'h00, a[3:1]} - 8'h01);
    end
    c = 0;
    while (scan_tick !== 1'b1 && c < 41000) begin
      @(posedge sys_clk);
      #1 c++;
    end
    {tx, ty, tz, tp} = '0;
    for (c = 1; c <= 40100; c++) begin
      @(posedge sys_clk);
      #1;
      if (sample_strobe[0] === 1'b1 && tx == 0) tx = c;
      if (sample_strobe[1] === 1'b1 && ty == 0) ty = c;
      if (sample_strobe[2] === 1'b1 && tz == 0) tz = c;
      if (scan_tick === 1'b1 && tp == 0) tp = c;
    end
    chk(16'(tx inside {[40:42]}), 16'h0001);
    chk(16'(ty - tx inside {[80:82]}), 16'h0001);
    chk(16'(tz - ty inside {[120:122]}), 16'h0001);
    chk(16'(tp inside {[39999:40001]}), 16'h0001);
  endtask : t_scan

  task automatic t_regs;
    rdc(4'hf, 8'h00);
    for (logic [3:0] a = ADDR_XDLY_HI; a <= ADDR_ZDLY_LO; a++) begin
      w(a, {4'h5, a});
      rdc(a, {4'h5, a});
    end
  endtask : t_regs

  task automatic t_cal;
    w(ADDR_TRIG, 8'h40);
    chk({15'h0, calibrating}, 16'h0001);
    cal_dly <= 16'h0203;
    @(posedge sys_clk);
    cal_dly_valid <= 1'b1;
    @(posedge sys_clk);
    cal_dly_valid <= 1'b0;
    rdc(ADDR_XDLY_HI, 8'h02);
    rdc(ADDR_YDLY_LO, 8'h02);
    rdc(ADDR_ZDLY_HI, 8'hfd);
    cal_points_done <= 1'b1;
    @(posedge sys_clk);
    cal_points_done <= 1'b0;
    #1 chk({15'h0, calibrating}, 16'h0000);
    w(ADDR_TRIG, 8'h40);
    w(ADDR_TRIG, 8'h00);
    chk({15'h0, calibrating}, 16'h0000);
    nv_trig <= 8'hff;
    nv_load <= 1'b1;
    @(posedge sys_clk);
    nv_load <= 1'b0;
    rdc(ADDR_TRIG, 8'hbf);
    chk({15'h0, calibrating}, 16'h0000);
  endtask : t_cal

  task automatic t_events;
    int tb[6] = '{BIT_RES, BIT_CAP, BIT_SLD, BIT_ROT, BIT_PINCH, BIT_REL};
    for (int i = 0; i < 6; i++) begin
      w(ADDR_TRIG, 8'h00);
      fire(6'(1 << i));
      chk({15'h0, activity_pending_pin}, 16'h0000);
      rdc(ADDR_STATUS, 8'h00);
      w(ADDR_TRIG, 8'(1 << tb[i]));
      fire(6'(1 << i));
      chk({15'h0, activity_pending_pin}, 16'h0001);
      rdc(ADDR_STATUS, 8'(1 << i));
      chk({15'h0, activity_pending_pin}, 16'h0000);
    end
  endtask : t_events

  task automatic t_queue;
    w(ADDR_TRIG, 8'(1 << BIT_QLVL));
    w(ADDR_QSETUP, 8'hf3);
    rdc(ADDR_QSETUP, 8'h13);
    push(2);
    chk({15'h0, queue_level_flag}, 16'h0000);
    push(1);
    @(posedge sys_clk);
    #1 chk({11'h0, queue_count}, 16'h0003);
    chk({14'h0, queue_level_flag, activity_pending_pin}, 16'h0003);
    @(posedge sys_clk);
    sample_pop <= 1'b1;
    @(posedge sys_clk);
    sample_pop <= 1'b0;
    #1 chk({11'h0, queue_count}, 16'h0002);
    w(ADDR_QSETUP, 8'h10);
    chk({11'h0, queue_count}, 16'h0000);
    push(15);
    chk({15'h0, queue_level_flag}, 16'h0000);
    push(2);
    chk({10'h0, queue_level_flag, queue_count}, 16'h0030);
    w(ADDR_QSETUP, 8'h03);
    push(1);
    chk({11'h0, queue_count}, 16'h0000);
    rdc(ADDR_STATUS, 8'h40);
    w(ADDR_TRIG, 8'h00);
  endtask : t_queue

  initial begin
    {sys_clk, rst_b, nv_load, cal_points_done, cal_dly_valid} = '0;
    {sample_valid, sample_pop, nv_trig, cal_dly, cyc} = '0;
    {bad_count, n_compared} = '0;
    ev = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(ADDR_PERIOD, PERIOD_RST);
    rdc(ADDR_XDLY_LO, DLY_RST[7:0]);
    t_regs;
    t_cal;
    t_events;
    t_queue;
    t_scan;
    tally_and_finish;
  end
endmodule : touch_event_trigger_config_tb
`default_nettype wire
